/* src/facrc_params.svh */
// Offsets, field positions, reset values and counts for the alarm and reset controller
`ifndef FACRC_PARAMS_SVH
`define FACRC_PARAMS_SVH
// ==========================================
// Register offsets (byte addresses)
`define FACRC_OFF_CTRL      8'h00
`define FACRC_OFF_CAUSE     8'h04
`define FACRC_OFF_TEST      8'h08
`define FACRC_OFF_WDT_LOAD  8'h0C
`define FACRC_OFF_CKPT      8'h10
`define FACRC_OFF_CKPT_EXP  8'h14
`define FACRC_OFF_ROM_REF   8'h18
`define FACRC_OFF_STATE     8'h1C
// ==========================================
// Control bit positions
`define FACRC_CTRL_TEST     0
`define FACRC_CTRL_HS_EN    1
`define FACRC_CTRL_TRAP_CLR 2
// ==========================================
// Alarm source indices
`define FACRC_SRC_N         10
`define FACRC_SRC_MEM       0
`define FACRC_SRC_FLASH     1
`define FACRC_SRC_ROM       2
`define FACRC_SRC_CORE      3
`define FACRC_SRC_TAMPER    4
`define FACRC_SRC_MMU       5
`define FACRC_SRC_OPCODE    6
`define FACRC_SRC_BACK      7
`define FACRC_SRC_HS        8
`define FACRC_SRC_WDT       9
// Sources that start a security reset
`define FACRC_CRIT_MASK     10'h0FF
// ==========================================
// Reset values and counts
`define FACRC_WDT_LOAD_RST  32'h0000_0000
`define FACRC_HS_TIMEOUT    8'h10
`define FACRC_WIPE_WORDS    8'h40
`define FACRC_LFSR_SEED     32'hACE1_2B5D
`endif

/* src/facrc_pkg.sv */
// Types shared by the alarm and reset controller
package facrc_pkg;
  // Security reset sequence, Gray coded
  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_HOLD = 2'b01,
    SR_WIPE = 2'b11,
    SR_DONE = 2'b10
  } facrc_sr_type;
  // Core result pair carried together
  typedef struct packed {
    logic        valid;
    logic [31:0] res_a;
    logic [31:0] res_b;
  } facrc_core_type;
  // Symmetric coprocessor forward and backward result
  typedef struct packed {
    logic        valid;
    logic [31:0] plain;
    logic [31:0] back;
  } facrc_back_type;
endpackage

/* src/facrc_top.sv */
// Fault alarm and security reset controller with Avalon-MM register slave
//
// How it works
// - Memory, encryption-unit and MMU path check failures raise an alarm.
// - Flash single-bit errors are corrected and the corrected byte returned.
// - A check value over ROM words is compared with a reference.
// - Power loss during flash programming aborts commit and requests power-on restart.
// - Results of both CPU parts are compared when both are valid.
// - A mismatch is recorded and starts the security reset sequence.
// - Software starts an alarm self-test; a pass bit per source is reported.
// - Tamper detection halts processing at once and enters security reset.
// - Coprocessor logic is held in reset and released at sequence end.
// - Keys are cleared and memory is overwritten with random words.
// - Watchdog with checkpoint register checks timing and program flow.
// - Coprocessor backward result must equal its input, else alarm.
// - A bus handshake not acknowledged in time raises an alarm if enabled.
// - MMU violation triggers reset then flags a trap for service.
// - An illegal opcode fetch starts a security reset.
// - Uncorrectable errors alarm; critical ones also force the secure state.
// - After RESET_N, MMU defaults load before user software runs; after a security reset USER_RUN rises on an MMU_INIT_DONE still held from before.
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "facrc_params.svh"
module facrc_top (
  input  wire logic                  CLK,
  input  wire logic                  RESET_N,
  input  wire logic [7:0]            AVS_ADDRESS,
  input  wire logic                  AVS_READ,
  input  wire logic                  AVS_WRITE,
  input  wire logic [31:0]           AVS_WRITEDATA,
  output logic [31:0]                AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  input  wire logic                  MEM_CHECK_FAIL,
  input  wire logic [12:0]           FLASH_CODEWORD,
  input  wire logic                  FLASH_RVALID,
  output logic [7:0]                 FLASH_RDATA,
  output logic                       FLASH_RDONE,
  input  wire logic                  FLASH_PROG_BUSY,
  output logic                       FLASH_COMMIT,
  output logic                       POR_REQ,
  input  wire logic                  POWER_FAIL,
  input  wire logic                  ROM_VALID,
  input  wire logic [31:0]           ROM_DATA,
  input  wire logic                  ROM_LAST,
  input  wire facrc_pkg::facrc_core_type CORE_RES,
  input  wire facrc_pkg::facrc_back_type SCP_RES,
  input  wire logic                  TAMPER,
  input  wire logic                  MMU_VIOLATION,
  input  wire logic                  ILLEGAL_OPCODE,
  input  wire logic                  BUS_REQ,
  input  wire logic                  BUS_ACK,
  input  wire logic                  MMU_INIT_DONE,
  output logic                       MMU_INIT,
  output logic                       USER_RUN,
  output logic                       CPU_HALT,
  output logic                       SEC_RESET_REQ,
  output logic                       COPRO_RESET,
  output logic                       KEY_CLEAR,
  output logic                       WIPE_WE,
  output logic [7:0]                 WIPE_ADDR,
  output logic [31:0]                WIPE_DATA,
  output logic                       TRAP_REQ,
  output logic                       ALARM
);
  import facrc_pkg::*;

  // ==========================================
  // Pin synchronisers: tamper, power fail
  logic [1:0] s1_ff, s2_ff, s3_ff, pin_hold_ff;
  logic [1:0] pin_in, pin_ok;
  assign pin_in = {POWER_FAIL, TAMPER};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          s1_ff[g] <= 1'b0;
          s2_ff[g] <= 1'b0;
          s3_ff[g] <= 1'b0;
          pin_hold_ff[g] <= 1'b0;
        end else begin
          s1_ff[g] <= pin_in[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          pin_hold_ff[g] <= pin_ok[g];
        end
      end
      assign pin_ok[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : pin_hold_ff[g];
    end
  endgenerate

  // ==========================================
  // Register bus
  logic        req, wr_acc;
  logic [31:0] ctrl_ff, wdt_load_ff, ckpt_exp_ff, rom_ref_ff;
  logic [`FACRC_SRC_N-1:0] cause_ff, test_res_ff;
  facrc_sr_type sr_ff;
  assign req    = AVS_READ | AVS_WRITE;
  assign wr_acc = AVS_WRITE & ~AVS_WAITREQUEST;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else begin
      AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
      if (AVS_READ & AVS_WAITREQUEST) begin
        case (AVS_ADDRESS)
          `FACRC_OFF_CTRL:     AVS_READDATA <= ctrl_ff;
          `FACRC_OFF_CAUSE:    AVS_READDATA <= {22'h0, cause_ff};
          `FACRC_OFF_TEST:     AVS_READDATA <= {22'h0, test_res_ff};
          `FACRC_OFF_WDT_LOAD: AVS_READDATA <= wdt_load_ff;
          `FACRC_OFF_CKPT_EXP: AVS_READDATA <= ckpt_exp_ff;
          `FACRC_OFF_ROM_REF:  AVS_READDATA <= rom_ref_ff;
          `FACRC_OFF_STATE:    AVS_READDATA <= {28'h0, TRAP_REQ, USER_RUN, sr_ff};
          default:             AVS_READDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control and configuration words
  logic test_go;
  assign test_go = wr_acc & (AVS_ADDRESS == `FACRC_OFF_CTRL)
                   & AVS_WRITEDATA[`FACRC_CTRL_TEST];
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_ff     <= 32'h0000_0000;
      wdt_load_ff <= `FACRC_WDT_LOAD_RST;
      ckpt_exp_ff <= 32'h0000_0000;
      rom_ref_ff  <= 32'h0000_0000;
    end else if (wr_acc) begin
      case (AVS_ADDRESS)
        `FACRC_OFF_CTRL:     ctrl_ff <= {30'h0, AVS_WRITEDATA[`FACRC_CTRL_HS_EN], 1'b0};
        `FACRC_OFF_WDT_LOAD: wdt_load_ff <= AVS_WRITEDATA;
        `FACRC_OFF_CKPT_EXP: ckpt_exp_ff <= AVS_WRITEDATA;
        `FACRC_OFF_ROM_REF:  rom_ref_ff <= AVS_WRITEDATA;
        default:             ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // ==========================================
  // Flash single-bit correction
  logic [3:0]  syn;
  logic        par;
  logic [12:0] fix;
  always_comb begin
    syn = 4'h0;
    for (int i = 1; i < 13; i++) begin
      if (FLASH_CODEWORD[i]) syn = syn ^ i[3:0];
    end
    par = ^FLASH_CODEWORD;
    fix = FLASH_CODEWORD;
    if (par && syn != 4'h0 && syn < 4'hD) fix[syn] = ~fix[syn];
  end
  logic flash_dbl;
  assign flash_dbl = FLASH_RVALID & ~par & (syn != 4'h0);
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FLASH_RDATA <= 8'h00;
      FLASH_RDONE <= 1'b0;
    end else begin
      FLASH_RDONE <= FLASH_RVALID;
      if (FLASH_RVALID) FLASH_RDATA <= {fix[12:9], fix[7:5], fix[3]};
    end
  end

  // ==========================================
  // Flash tear protection
  logic busy_d_ff, tear_ff;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_d_ff    <= 1'b0;
      tear_ff      <= 1'b0;
      FLASH_COMMIT <= 1'b0;
      POR_REQ      <= 1'b0;
    end else begin
      busy_d_ff    <= FLASH_PROG_BUSY;
      if (FLASH_PROG_BUSY & pin_ok[1]) tear_ff <= 1'b1;
      else if (FLASH_PROG_BUSY & ~busy_d_ff) tear_ff <= 1'b0;
      FLASH_COMMIT <= busy_d_ff & ~FLASH_PROG_BUSY & ~tear_ff & ~pin_ok[1];
      if (FLASH_PROG_BUSY & pin_ok[1]) POR_REQ <= 1'b1;
    end
  end

  // ==========================================
  // ROM check accumulator
  logic [31:0] rom_acc_ff;
  logic        rom_bad;
  assign rom_bad = ROM_VALID & ROM_LAST & ((rom_acc_ff ^ ROM_DATA) != rom_ref_ff);
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) rom_acc_ff <= 32'h0000_0000;
    else if (ROM_VALID) rom_acc_ff <= ROM_LAST ? 32'h0000_0000 : rom_acc_ff ^ ROM_DATA;
  end

  // ==========================================
  // Watchdog and checkpoint
  logic [31:0] wdt_ff;
  logic        ckpt_wr, wdt_evt;
  assign ckpt_wr = wr_acc & (AVS_ADDRESS == `FACRC_OFF_CKPT);
  assign wdt_evt = (ckpt_wr & (AVS_WRITEDATA != ckpt_exp_ff))
                   | ((wdt_load_ff != 32'h0) & (wdt_ff == 32'h1));
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) wdt_ff <= 32'h0000_0000;
    else if (ckpt_wr | (wdt_ff == 32'h0) | wdt_evt) wdt_ff <= wdt_load_ff;
    else wdt_ff <= wdt_ff - 32'h1;
  end

  // ==========================================
  // Bus handshake monitor
  logic [7:0] hs_ff;
  logic       hs_evt;
  assign hs_evt = ctrl_ff[`FACRC_CTRL_HS_EN] & (hs_ff == `FACRC_HS_TIMEOUT);
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) hs_ff <= 8'h00;
    else if (~BUS_REQ | BUS_ACK | hs_evt) hs_ff <= 8'h00;
    else if (hs_ff != `FACRC_HS_TIMEOUT) hs_ff <= hs_ff + 8'h01;
  end

  // ==========================================
  // Alarm sources, self-test injection
  logic [`FACRC_SRC_N-1:0] evt, inj_ff, inj_d_ff, det_ff;
  logic                    testing_ff;
  assign evt[`FACRC_SRC_MEM]    = MEM_CHECK_FAIL;
  assign evt[`FACRC_SRC_FLASH]  = flash_dbl;
  assign evt[`FACRC_SRC_ROM]    = rom_bad;
  assign evt[`FACRC_SRC_CORE]   = CORE_RES.valid & (CORE_RES.res_a != CORE_RES.res_b);
  assign evt[`FACRC_SRC_TAMPER] = pin_ok[0];
  assign evt[`FACRC_SRC_MMU]    = MMU_VIOLATION;
  assign evt[`FACRC_SRC_OPCODE] = ILLEGAL_OPCODE;
  assign evt[`FACRC_SRC_BACK]   = SCP_RES.valid & (SCP_RES.back != SCP_RES.plain);
  assign evt[`FACRC_SRC_HS]     = hs_evt;
  assign evt[`FACRC_SRC_WDT]    = wdt_evt;
  generate
    for (g = 0; g < `FACRC_SRC_N; g++) begin : g_src
      always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          det_ff[g]      <= 1'b0;
          test_res_ff[g] <= 1'b0;
        end else begin
          det_ff[g] <= evt[g] | inj_ff[g];
          if (inj_d_ff[g] & det_ff[g]) test_res_ff[g] <= 1'b1;
          else if (test_go) test_res_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      inj_ff     <= '0;
      inj_d_ff   <= '0;
      testing_ff <= 1'b0;
    end else begin
      inj_d_ff <= inj_ff;
      if (test_go & ~testing_ff) begin
        inj_ff     <= {{(`FACRC_SRC_N-1){1'b0}}, 1'b1};
        testing_ff <= 1'b1;
      end else if (testing_ff) begin
        inj_ff     <= {inj_ff[`FACRC_SRC_N-2:0], 1'b0};
        testing_ff <= (inj_ff != '0) | (inj_d_ff != '0);
      end
    end
  end

  // ==========================================
  // Cause recording and alarm combine
  logic [`FACRC_SRC_N-1:0] live;
  logic                    crit;
  assign live = det_ff & ~inj_d_ff;
  assign crit = |(live & `FACRC_CRIT_MASK);
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cause_ff <= '0;
      ALARM    <= 1'b0;
    end else begin
      if (live != '0) cause_ff <= live;
      ALARM <= |live;
    end
  end

  // ==========================================
  // Security reset sequence
  logic [31:0] lfsr_ff;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sr_ff         <= SR_IDLE;
      SEC_RESET_REQ <= 1'b0;
      CPU_HALT      <= 1'b0;
      COPRO_RESET   <= 1'b0;
      KEY_CLEAR     <= 1'b0;
      WIPE_WE       <= 1'b0;
      WIPE_ADDR     <= 8'h00;
    end else begin
      KEY_CLEAR <= 1'b0;
      case (sr_ff)
        SR_IDLE: begin
          if (crit) begin
            sr_ff         <= SR_HOLD;
            SEC_RESET_REQ <= 1'b1;
            CPU_HALT      <= 1'b1;
            COPRO_RESET   <= 1'b1;
          end
        end
        SR_HOLD: begin
          KEY_CLEAR <= 1'b1;
          WIPE_ADDR <= 8'h00;
          sr_ff     <= SR_WIPE;
        end
        SR_WIPE: begin
          WIPE_WE <= 1'b1;
          if (WIPE_WE) WIPE_ADDR <= WIPE_ADDR + 8'h01;
          if (WIPE_WE & (WIPE_ADDR == `FACRC_WIPE_WORDS - 8'h01)) begin
            WIPE_WE <= 1'b0;
            sr_ff   <= SR_DONE;
          end
        end
        SR_DONE: begin
          COPRO_RESET   <= 1'b0;
          SEC_RESET_REQ <= 1'b0;
          CPU_HALT      <= 1'b0;
          sr_ff         <= SR_IDLE;
        end
        default: sr_ff <= SR_IDLE;
      endcase
    end
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lfsr_ff   <= `FACRC_LFSR_SEED;
      WIPE_DATA <= 32'h0000_0000;
    end else begin
      lfsr_ff   <= {lfsr_ff[30:0], lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0]};
      WIPE_DATA <= (sr_ff == SR_WIPE) ? lfsr_ff : 32'h0000_0000;
    end
  end

  // ==========================================
  // Trap flag and startup MMU defaults
  logic trap_clr, boot_ff;
  assign trap_clr = wr_acc & (AVS_ADDRESS == `FACRC_OFF_CTRL)
                    & AVS_WRITEDATA[`FACRC_CTRL_TRAP_CLR];
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TRAP_REQ <= 1'b0;
      MMU_INIT <= 1'b0;
      USER_RUN <= 1'b0;
      boot_ff  <= 1'b1;
    end else begin
      if (live[`FACRC_SRC_MMU] & (sr_ff == SR_DONE)) TRAP_REQ <= 1'b1;
      else if (cause_ff[`FACRC_SRC_MMU] & (sr_ff == SR_DONE)) TRAP_REQ <= 1'b1;
      else if (trap_clr) TRAP_REQ <= 1'b0;
      MMU_INIT <= boot_ff | (sr_ff == SR_DONE);
      boot_ff  <= 1'b0;
      if (boot_ff | (sr_ff != SR_IDLE)) USER_RUN <= 1'b0;
      else if (MMU_INIT_DONE) USER_RUN <= 1'b1;
    end
  end
endmodule

/* sim/facrc_far_model.sv */
// Far-side model: bus target handshake and MMU setup by system software
`timescale 1ns/1ps
module facrc_far_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic slow,
  input  wire logic bus_req,
  input  wire logic mmu_init,
  output logic      bus_ack,
  output logic      mmu_init_done
);
  logic [4:0] ack_cnt_ff;
  logic [2:0] cfg_cnt_ff;
  // ==========================================
  // Bus target: ack after 2 cycles, or after 31 when slow
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ack_cnt_ff <= '0;
    else if (!bus_req) ack_cnt_ff <= '0;
    else if (ack_cnt_ff != 5'h1F) ack_cnt_ff <= ack_cnt_ff + 5'h01;
  end
  assign bus_ack = bus_req && (slow ? ack_cnt_ff == 5'h1F : ack_cnt_ff >= 5'h02);
  // ==========================================
  // Software sets up ranges after each init pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cfg_cnt_ff <= '0;
    else if (mmu_init) cfg_cnt_ff <= 3'h1;
    else if (cfg_cnt_ff != 3'h0 && cfg_cnt_ff != 3'h5) cfg_cnt_ff <= cfg_cnt_ff + 3'h1;
  end
  assign mmu_init_done = cfg_cnt_ff == 3'h5;
endmodule

/* sim/facrc_top_monitor.sv */
// Port-level assertions for the alarm and reset controller
`timescale 1ns/1ps
module facrc_top_monitor (
  input wire logic                      CLK,
  input wire logic                      RESET_N,
  input wire logic                      AVS_WAITREQUEST,
  input wire logic                      FLASH_RVALID,
  input wire logic                      FLASH_RDONE,
  input wire logic                      POR_REQ,
  input wire facrc_pkg::facrc_core_type CORE_RES,
  input wire logic                      TAMPER,
  input wire logic                      ILLEGAL_OPCODE,
  input wire logic                      CPU_HALT,
  input wire logic                      SEC_RESET_REQ,
  input wire logic                      COPRO_RESET,
  input wire logic                      KEY_CLEAR,
  input wire logic                      WIPE_WE,
  input wire logic [7:0]                WIPE_ADDR,
  input wire logic                      ALARM
);
  import facrc_pkg::*;
  default clocking dcb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // ==========================================
  // Assertions
  AST_WAIT_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  AST_FLASH_DONE: assert property (FLASH_RVALID |=> FLASH_RDONE)
    else $error("flash read not answered next cycle");
  AST_POR_STICKY: assert property (POR_REQ |=> POR_REQ)
    else $error("restart request dropped");
  AST_CORE_MISMATCH: assert property (CORE_RES.valid && CORE_RES.res_a != CORE_RES.res_b
    && !SEC_RESET_REQ |-> ##[2:3] (ALARM && SEC_RESET_REQ)) else $error("mismatch not acted on");
  AST_TAMPER_HALT: assert property ($rose(TAMPER) |-> ##[1:8] CPU_HALT)
    else $error("tamper did not halt");
  AST_OPCODE_RESET: assert property (ILLEGAL_OPCODE && !SEC_RESET_REQ |-> ##[2:3] SEC_RESET_REQ)
    else $error("illegal opcode without reset");
  AST_KEY_PULSE: assert property (KEY_CLEAR |-> SEC_RESET_REQ ##1 !KEY_CLEAR)
    else $error("key clear outside sequence or too long");
  AST_WIPE_SEQ: assert property (WIPE_WE && WIPE_ADDR != 8'h3F |=>
    WIPE_WE && WIPE_ADDR == $past(WIPE_ADDR) + 8'h01) else $error("wipe address broken");
  AST_WIPE_HELD: assert property (WIPE_WE |-> SEC_RESET_REQ && COPRO_RESET && CPU_HALT)
    else $error("wipe without reset levels");
  cover property (KEY_CLEAR);
  cover property ($rose(POR_REQ));
  cover property (FLASH_RDONE);
endmodule
bind facrc_top facrc_top_monitor u_facrc_top_monitor (.*);

/* sim/tb_top.sv */
// Self-checking bench for the alarm and reset controller
`timescale 1ns/1ps
`include "facrc_params.svh"
module tb_top;
  import facrc_pkg::*;
  logic           CLK, RESET_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, MEM_CHECK_FAIL;
  logic           FLASH_RVALID, FLASH_RDONE, FLASH_PROG_BUSY, FLASH_COMMIT, POR_REQ;
  logic           POWER_FAIL, ROM_VALID, ROM_LAST, TAMPER, MMU_VIOLATION, ILLEGAL_OPCODE;
  logic           BUS_REQ, BUS_ACK, MMU_INIT_DONE, MMU_INIT, USER_RUN, CPU_HALT, slow;
  logic           SEC_RESET_REQ, COPRO_RESET, KEY_CLEAR, WIPE_WE, TRAP_REQ, ALARM, alarm_d;
  logic [7:0]     AVS_ADDRESS, FLASH_RDATA, WIPE_ADDR;
  logic [12:0]    FLASH_CODEWORD;
  logic [31:0]    AVS_WRITEDATA, AVS_READDATA, ROM_DATA, WIPE_DATA, q, wipe_prev;
  facrc_core_type CORE_RES;
  facrc_back_type SCP_RES;
  int             failures = 0, n_compared = 0, n_alarm = 0, n_wipe = 0, n_key = 0;
  int             n_commit = 0, n_flat = 0, a, w, kc, c;
  // Rows: corrected byte in [11:4], flipped codeword bit in [3:0]
  logic [11:0]    fl_row [6] = '{12'h5A3, 12'hA50, 12'hFF7, 12'h00C, 12'h3C1, 12'h965};
  facrc_top u_facrc_top (.*);
  facrc_far_model u_facrc_far_model (
    .clk           (CLK),
    .reset_n       (RESET_N),
    .slow          (slow),
    .bus_req       (BUS_REQ),
    .mmu_init      (MMU_INIT),
    .bus_ack       (BUS_ACK),
    .mmu_init_done (MMU_INIT_DONE)
  );
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    alarm_d <= ALARM;
    wipe_prev <= WIPE_DATA;
    if (ALARM === 1'b1 && alarm_d !== 1'b1) n_alarm <= n_alarm + 1;
    if (WIPE_WE === 1'b1) n_wipe <= n_wipe + 1;
    if (WIPE_WE === 1'b1 && (WIPE_DATA === 32'h0 || WIPE_DATA === wipe_prev)) n_flat <= n_flat + 1;
    if (KEY_CLEAR === 1'b1) n_key <= n_key + 1;
    if (FLASH_COMMIT === 1'b1) n_commit <= n_commit + 1;
  end
  // ==========================================
  // Helpers
  task automatic report_and_stop;
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = n_alarm != a;
      1: pick = SEC_RESET_REQ;
      2: pick = USER_RUN;
      default: pick = AVS_WAITREQUEST;
    endcase
  endfunction
  task automatic wait_for(input int s, input logic v);
    for (int k = 0; pick(s) !== v; k++) begin
      if (k == 400) begin
        failures++;
        report_and_stop;
      end
      @(posedge CLK);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    AVS_ADDRESS <= ad;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    wait_for(3, 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLK);
  endtask
  function automatic logic [12:0] enc(input logic [7:0] d);
    logic [12:0] cw;
    cw = '0;
    {cw[12:9], cw[7:5], cw[3]} = d;
    for (int p = 1; p < 16; p = p * 2)
      for (int j = 1; j < 13; j++)
        if ((j & p) != 0 && j != p) cw[p] = cw[p] ^ cw[j];
    cw[0] = ^cw[12:1];
    return cw;
  endfunction
  task automatic do_reset(input int n);
    @(posedge CLK);
    RESET_N <= 1'b0;
    repeat (n) @(posedge CLK);
    check({AVS_WAITREQUEST, SEC_RESET_REQ, POR_REQ, ALARM}, 4'h8);
    RESET_N <= 1'b1;
    repeat (2) @(posedge CLK);
    check(MMU_INIT, 1'b1);
    wait_for(2, 1'b1);
    check(MMU_INIT_DONE, 1'b1);
  endtask
  task automatic inject(input int i);
    case (i)
      0: MEM_CHECK_FAIL <= 1'b1;
      1: begin
        FLASH_CODEWORD <= enc(8'h3C) ^ 13'h0028;
        FLASH_RVALID <= 1'b1;
      end
      2: begin
        ROM_DATA <= 32'h0F0F_0F0E;
        {ROM_VALID, ROM_LAST} <= 2'b11;
      end
      3: CORE_RES <= {1'b1, 32'h1234_5678, 32'h1234_5679};
      4: TAMPER <= 1'b1;
      5: MMU_VIOLATION <= 1'b1;
      6: ILLEGAL_OPCODE <= 1'b1;
      7: SCP_RES <= {1'b1, 32'hCAFE_0001, 32'hCAFE_0003};
      8: BUS_REQ <= 1'b1;
      default: begin
        bus(1'b1, `FACRC_OFF_CKPT_EXP, 32'h5);
        bus(1'b1, `FACRC_OFF_CKPT, 32'h6);
      end
    endcase
    @(posedge CLK);
    {MEM_CHECK_FAIL, FLASH_RVALID, ROM_VALID, ROM_LAST, MMU_VIOLATION, ILLEGAL_OPCODE} <= '0;
    CORE_RES.valid <= 1'b0;
    SCP_RES.valid <= 1'b0;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {RESET_N, AVS_READ, AVS_WRITE, MEM_CHECK_FAIL, FLASH_RVALID, FLASH_PROG_BUSY} = '0;
    {POWER_FAIL, ROM_VALID, ROM_LAST, TAMPER, MMU_VIOLATION, ILLEGAL_OPCODE, BUS_REQ, slow} = '0;
    {AVS_ADDRESS, AVS_WRITEDATA, FLASH_CODEWORD, ROM_DATA, CORE_RES, SCP_RES} = '0;
    do_reset(20);
    bus(1'b1, `FACRC_OFF_CAUSE, 32'hFFFF);
    bus(1'b0, `FACRC_OFF_CAUSE, 32'h0);
    check(q, 32'h0);
    bus(1'b0, 8'h20, 32'h0);
    check(q, 32'h0);
    bus(1'b1, `FACRC_OFF_CTRL, 32'h2);
    bus(1'b0, `FACRC_OFF_CTRL, 32'h0);
    check(q, 32'h2);
    bus(1'b1, `FACRC_OFF_ROM_REF, 32'h0F0F_0F0F);
    a = n_alarm;
    ROM_DATA <= 32'h0F0F_0F0F;
    {ROM_VALID, ROM_LAST, BUS_REQ} <= 3'b111;
    @(posedge CLK);
    {ROM_VALID, ROM_LAST} <= 2'b00;
    repeat (23) @(posedge CLK);
    BUS_REQ <= 1'b0;
    slow <= 1'b1;
    foreach (fl_row[r]) begin
      FLASH_CODEWORD <= enc(fl_row[r][11:4]) ^ (13'h0001 << fl_row[r][3:0]);
      FLASH_RVALID <= 1'b1;
      @(posedge CLK);
      FLASH_RVALID <= 1'b0;
      @(posedge CLK);
      check({FLASH_RDONE, FLASH_RDATA}, {1'b1, fl_row[r][11:4]});
    end
    check(n_alarm - a, 0);
    bus(1'b1, `FACRC_OFF_CTRL, 32'h3);
    repeat (12) @(posedge CLK);
    bus(1'b0, `FACRC_OFF_TEST, 32'h0);
    check(q, 32'h3FF);
    check(n_alarm - a, 0);
    check(SEC_RESET_REQ, 1'b0);
    for (int i = 0; i < `FACRC_SRC_N; i++) begin
      a = n_alarm;
      w = n_wipe;
      kc = n_key;
      inject(i);
      wait_for(0, 1'b1);
      TAMPER <= 1'b0;
      BUS_REQ <= 1'b0;
      if (i < 8) begin
        wait_for(1, 1'b0);
        wait_for(2, 1'b1);
      end
      @(posedge CLK);
      check(n_alarm - a, 1);
      check(n_wipe - w, (i < 8) ? 64 : 0);
      check(n_key - kc, (i < 8) ? 1 : 0);
      check({CPU_HALT, COPRO_RESET, SEC_RESET_REQ}, 3'b000);
      bus(1'b0, `FACRC_OFF_CAUSE, 32'h0);
      check(q, 32'h1 << i);
      check(TRAP_REQ, i == 5);
      if (i == 5) begin
        bus(1'b1, `FACRC_OFF_CTRL, 32'h6);
        check(TRAP_REQ, 1'b0);
      end
    end
    check(n_flat, 0);
    a = n_alarm;
    bus(1'b1, `FACRC_OFF_WDT_LOAD, 32'h20);
    wait_for(0, 1'b1);
    bus(1'b1, `FACRC_OFF_WDT_LOAD, 32'h0);
    bus(1'b0, `FACRC_OFF_CAUSE, 32'h0);
    check(q, 32'h1 << `FACRC_SRC_WDT);
    check(n_alarm - a, 1);
    c = n_commit;
    FLASH_PROG_BUSY <= 1'b1;
    repeat (4) @(posedge CLK);
    FLASH_PROG_BUSY <= 1'b0;
    repeat (4) @(posedge CLK);
    check(n_commit - c, 1);
    FLASH_PROG_BUSY <= 1'b1;
    POWER_FAIL <= 1'b1;
    repeat (6) @(posedge CLK);
    FLASH_PROG_BUSY <= 1'b0;
    repeat (4) @(posedge CLK);
    check(n_commit - c, 1);
    check(POR_REQ, 1'b1);
    POWER_FAIL <= 1'b0;
    do_reset(3);
    report_and_stop;
  end
endmodule
